/* File: src/lcdp_pkg.sv */
// Shared constants and types for the LCD controller host bus port.
package lcdp_pkg;

  // Strap codes on bus_type_select; any other code falls back to the generic strobe style.
  localparam logic [1:0] LCDP_BT_GENERIC = 2'h0;
  localparam logic [1:0] LCDP_BT_ENABLE  = 2'h1;
  localparam logic [1:0] LCDP_BT_ADDR    = 2'h2;

  // Clock rate and the wait-state time inserted before a transfer completes.
  localparam int LCDP_CLK_MHZ  = 25;
  localparam int LCDP_WAIT_NS  = 80;
  // Least time, so the cycle count rounds up.
  localparam int LCDP_WAIT_CYC = (LCDP_WAIT_NS * LCDP_CLK_MHZ + 999) / 1000;
  localparam logic [2:0] LCDP_WAIT_LOAD = 3'(LCDP_WAIT_CYC);

  // Cycles after reset release before the straps are taken, covering the synchroniser depth.
  localparam logic [2:0] LCDP_STRAP_SETTLE = 3'h4;

  // Field widths and reset values.
  localparam int          LCDP_DATA_W    = 8;
  localparam int          LCDP_PIN_W     = 12;
  localparam int          LCDP_STRAP_W   = 3;
  localparam logic [11:0] LCDP_PINS_RST  = 12'hf00;
  localparam logic [2:0]  LCDP_STRAP_RST = 3'h0;
  localparam logic [7:0]  LCDP_DATA_RST  = 8'h00;

  // Bus style selected by the straps.
  typedef enum logic [1:0] {
    LCDP_MODE_GENERIC,
    LCDP_MODE_ENABLE,
    LCDP_MODE_ADDR
  } lcdp_mode_t;

  // Transfer sequencer states.
  typedef enum logic [1:0] {
    LCDP_ST_IDLE,
    LCDP_ST_BUSY,
    LCDP_ST_ACK
  } lcdp_state_t;

  // Host-facing input pins, carried together through the synchroniser.
  typedef struct packed {
    logic       unit_select_n;
    logic       store_strobe_n;
    logic       fetch_strobe_n;
    logic       address_valid_strobe_n;
    logic [7:0] data;
  } lcdp_pins_t;

  // Static strap pins.
  typedef struct packed {
    logic [1:0] bus_type_select;
    logic       addressing_mode_select;
  } lcdp_straps_t;

endpackage : lcdp_pkg

/* File: src/lcdp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with agreement filter: the output only follows once stages two and three agree.
module lcdp_sync
  import lcdp_pkg::*;
#(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_sync_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] filt_out
);

  logic [W-1:0] s1_q;  // First stage, read only by the second.
  logic [W-1:0] s2_q;  // Second stage.
  logic [W-1:0] s3_q;  // Third stage.

  // Shift the pins through three stages and accept a value once it has held for two samples.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_q     <= INIT;
      s2_q     <= INIT;
      s3_q     <= INIT;
      filt_out <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        filt_out <= s3_q;
      end
    end
  end

endmodule // lcdp_sync

`default_nettype wire

/* File: src/lcdp_host_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Generic write data taken at store strobe rise.
// - Enable style: pin high reads, low writes.
// - Address style: pin high reads, low writes.
// - Transfers happen only while unit select low.
// - Generic style: hold-off low while transfer waits.
// - Handshake released to high impedance after completion.
// - Address style: ack high waits, then low.
// - Reset clears registers and quiets all outputs.
// - Generic read drivers on only while fetch low.
// - Enable style moves data on enable rise.
// - Address style moves data on strobe fall.
// - Straps choose bus style and addressing mode.
module lcdp_host_port
  import lcdp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       unit_select_n,
  input  wire logic       store_strobe_n,
  input  wire logic       fetch_strobe_n,
  input  wire logic       address_valid_strobe_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            handshake_out,
  output logic            handshake_oe,
  input  wire logic [1:0] bus_type_select,
  input  wire logic       addressing_mode_select,
  input  wire logic       scan_test_tie,
  input  wire logic       test_mode_tie,
  output logic            core_wr_valid,
  output logic      [7:0] core_wr_data,
  output logic            core_rd_req,
  input  wire logic [7:0] core_rd_data,
  output logic      [1:0] bus_mode,
  output logic            indirect_mode
);

  // Strobe decode for the selected style; used for the current and the previous sample.
  function automatic logic strobe_active(lcdp_mode_t m, lcdp_pins_t p);
    case (m)
      LCDP_MODE_ENABLE: strobe_active = p.fetch_strobe_n;
      LCDP_MODE_ADDR:   strobe_active = ~p.fetch_strobe_n & ~p.address_valid_strobe_n;
      default:          strobe_active = ~p.fetch_strobe_n | ~p.store_strobe_n;
    endcase
  endfunction

  // Direction decode: high means the host reads from this port.
  function automatic logic read_dir(lcdp_mode_t m, lcdp_pins_t p);
    case (m)
      LCDP_MODE_ENABLE: read_dir = p.store_strobe_n;
      LCDP_MODE_ADDR:   read_dir = p.store_strobe_n;
      default:          read_dir = ~p.fetch_strobe_n;
    endcase
  endfunction

  logic         rst_q1;          // Reset release, first stage.
  logic         rst_q2;          // Reset release, copy used by the design.
  lcdp_pins_t   pins_f;          // Filtered host pins.
  lcdp_straps_t straps_f;        // Filtered strap pins.
  lcdp_mode_t   mode_q;          // Bus style held since the straps were taken.
  logic         indirect_q;      // Addressing mode held since the straps were taken.
  logic         taken_q;         // Straps have been taken.
  logic [2:0]   settle_q;        // Counts towards the strap sampling point.
  lcdp_state_t  state_q;         // Transfer sequencer state.
  lcdp_state_t  state_d;         // Next sequencer state.
  logic [2:0]   wait_q;          // Remaining wait-state cycles.
  logic         strobe_prev_q;   // Strobe decode of the previous cycle.
  logic         store_prev_q;    // Filtered store strobe of the previous cycle.
  logic         is_read_q;       // Current transfer is a read.
  logic [7:0]   data_hold_q;     // Bus data last seen while the store strobe was low.
  logic [7:0]   data_out_q;      // Read data presented on the bus.
  logic         data_oe_q;       // Data driver enable.
  logic         hs_out_q;        // Handshake level.
  logic         hs_oe_q;         // Handshake driver enable.
  logic         wr_valid_q;      // One-cycle write pulse to the core.
  logic [7:0]   wr_data_q;       // Write data to the core.
  logic         rd_req_q;        // One-cycle read request to the core.

  // Decoded bus conditions.
  wire logic selected   = ~pins_f.unit_select_n;
  wire logic strobe_on  = strobe_active(mode_q, pins_f);
  wire logic start      = taken_q & selected & strobe_on & ~strobe_prev_q & (state_q == LCDP_ST_IDLE);
  wire logic start_rd   = read_dir(mode_q, pins_f);
  wire logic xfer_end   = ~selected | ~strobe_on;
  wire logic busy_done  = (state_q == LCDP_ST_BUSY) & (wait_q <= 3'h1);
  wire logic gen_store_rise = (mode_q == LCDP_MODE_GENERIC) & pins_f.store_strobe_n & ~store_prev_q;
  wire logic gen_write  = (state_q != LCDP_ST_IDLE) & ~is_read_q & gen_store_rise;
  wire logic early_write = start & ~start_rd & (mode_q != LCDP_MODE_GENERIC);
  wire logic hs_used    = (mode_q != LCDP_MODE_ENABLE);
  wire logic wait_level = (mode_q == LCDP_MODE_ADDR);
  wire logic hs_oe_d    = hs_used & (state_d != LCDP_ST_IDLE);
  wire logic hs_out_d   = (state_d == LCDP_ST_BUSY) ? wait_level : ~wait_level;
  wire logic rd_now     = (state_q == LCDP_ST_IDLE) ? (start & start_rd) : is_read_q;
  wire logic data_oe_d  = rd_now & selected & strobe_on & (state_d != LCDP_ST_IDLE);

  // Strap decode into a bus style.
  wire lcdp_mode_t strap_mode = (straps_f.bus_type_select == LCDP_BT_ENABLE) ? LCDP_MODE_ENABLE :
                                (straps_f.bus_type_select == LCDP_BT_ADDR)   ? LCDP_MODE_ADDR   :
                                                                               LCDP_MODE_GENERIC;

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Host pins pass three stages with agreement filtering.
  lcdp_sync #(.W(LCDP_PIN_W), .INIT(LCDP_PINS_RST)) u_pin_sync (
    .clk        (clk),
    .rst_sync_b (rst_q2),
    .async_in   ({unit_select_n, store_strobe_n, fetch_strobe_n, address_valid_strobe_n, data_in}),
    .filt_out   (pins_f)
  );

  // Strap pins pass the same filter before they are taken.
  lcdp_sync #(.W(LCDP_STRAP_W), .INIT(LCDP_STRAP_RST)) u_strap_sync (
    .clk        (clk),
    .rst_sync_b (rst_q2),
    .async_in   ({bus_type_select, addressing_mode_select}),
    .filt_out   (straps_f)
  );

  // Take the straps once after the filter has settled; afterwards the style is constant.
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      settle_q   <= 3'h0;
      taken_q    <= 1'b0;
      mode_q     <= LCDP_MODE_GENERIC;
      indirect_q <= 1'b0;
    end else if (!taken_q) begin
      settle_q <= settle_q + 3'h1;
      if (settle_q == LCDP_STRAP_SETTLE) begin
        taken_q    <= 1'b1;
        mode_q     <= strap_mode;
        indirect_q <= straps_f.addressing_mode_select;
      end
    end
  end

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      LCDP_ST_IDLE: begin
        if (start) begin
          state_d = LCDP_ST_BUSY;
        end
      end
      LCDP_ST_BUSY: begin
        if (xfer_end) begin
          state_d = LCDP_ST_IDLE;
        end else if (busy_done) begin
          state_d = LCDP_ST_ACK;
        end
      end
      LCDP_ST_ACK: begin
        if (xfer_end) begin
          state_d = LCDP_ST_IDLE;
        end
      end
      default: begin
        state_d = LCDP_ST_IDLE;
      end
    endcase
  end

  // Sequencer state, wait counter and edge history.
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      state_q       <= LCDP_ST_IDLE;
      wait_q        <= 3'h0;
      strobe_prev_q <= 1'b0;
      store_prev_q  <= 1'b1;
      is_read_q     <= 1'b0;
    end else begin
      state_q       <= state_d;
      strobe_prev_q <= strobe_on;
      store_prev_q  <= pins_f.store_strobe_n;
      if (start) begin
        wait_q    <= LCDP_WAIT_LOAD;
        is_read_q <= start_rd;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end

  // Handshake and data drivers follow the next state so they line up with it.
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      hs_out_q   <= 1'b1;
      hs_oe_q    <= 1'b0;
      data_oe_q  <= 1'b0;
      data_out_q <= LCDP_DATA_RST;
    end else begin
      hs_out_q  <= hs_out_d;
      hs_oe_q   <= hs_oe_d;
      data_oe_q <= data_oe_d;
      if (busy_done & is_read_q) begin
        data_out_q <= core_rd_data;
      end
    end
  end

  // Core side: read request at start, write pulse at the capture point of the style.
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      rd_req_q    <= 1'b0;
      wr_valid_q  <= 1'b0;
      wr_data_q   <= LCDP_DATA_RST;
      data_hold_q <= LCDP_DATA_RST;
    end else begin
      rd_req_q   <= start & start_rd;
      wr_valid_q <= gen_write | early_write;
      if (!pins_f.store_strobe_n) begin
        data_hold_q <= pins_f.data;
      end
      if (gen_write) begin
        wr_data_q <= data_hold_q;
      end else if (early_write) begin
        wr_data_q <= pins_f.data;
      end
    end
  end

  assign data_out      = data_out_q;
  assign data_oe       = data_oe_q;
  assign handshake_out = hs_out_q;
  assign handshake_oe  = hs_oe_q;
  assign core_wr_valid = wr_valid_q;
  assign core_wr_data  = wr_data_q;
  assign core_rd_req   = rd_req_q;
  assign bus_mode      = mode_q;
  assign indirect_mode = indirect_q;

  // Checks on the sequencer and drivers.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q2);

  AST_IDLE_WITHOUT_SELECT: assert property ((state_q == LCDP_ST_IDLE) && !selected |=> state_q == LCDP_ST_IDLE)
    else $error("Transfer started without unit select.");
  AST_GEN_WRITE_ON_RISE: assert property (wr_valid_q && (mode_q == LCDP_MODE_GENERIC)
                                          |-> $past(pins_f.store_strobe_n) && !$past(store_prev_q))
    else $error("Generic write not taken at store strobe rise.");
  AST_GEN_WAIT_LOW: assert property ((state_q == LCDP_ST_BUSY) && (mode_q == LCDP_MODE_GENERIC)
                                     |=> (state_q != LCDP_ST_BUSY) || (hs_oe_q && !hs_out_q))
    else $error("Hold-off not driven low during wait.");
  AST_RELEASE_IDLE: assert property ($fell(state_q != LCDP_ST_IDLE) |-> !hs_oe_q ##1 !hs_oe_q)
    else $error("Handshake still driven after completion.");
  AST_ADDR_ACK_LEVELS: assert property ((mode_q == LCDP_MODE_ADDR) && (state_q == LCDP_ST_ACK)
                                        |-> hs_oe_q && !hs_out_q)
    else $error("Acknowledge level wrong in address style.");
  AST_ENABLE_NO_HANDSHAKE: assert property ((mode_q == LCDP_MODE_ENABLE) |-> !hs_oe_q)
    else $error("Handshake driven in enable style.");
  AST_READ_DRIVE_GATED: assert property (data_oe_q |-> $past(selected && strobe_on) && is_read_q)
    else $error("Data drivers on outside a read strobe.");
  AST_MODE_FROZEN: assert property (taken_q |=> $stable(mode_q) && $stable(indirect_q))
    else $error("Bus style changed after straps were taken.");
  AST_RESET_QUIET: assert property ($rose(rst_q2) |-> !hs_oe_q && !data_oe_q && !wr_valid_q && !rd_req_q)
    else $error("Outputs active on reset release.");
  AST_WAIT_LENGTH: assert property ($rose(state_q == LCDP_ST_BUSY) |-> ##[1:4] state_q != LCDP_ST_BUSY)
    else $error("Wait states exceed their length.");

endmodule // lcdp_host_port

`default_nettype wire

/* File: tb/lcdp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host processor model: runs one byte transfer per call and paces itself on the handshake, or on a fixed time in the enable style.
module lcdp_host_model
  import lcdp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       handshake_out,
  input  wire logic       handshake_oe,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            unit_select_n,
  output logic            store_strobe_n,
  output logic            fetch_strobe_n,
  output logic            address_valid_strobe_n,
  output logic      [7:0] data_in,
  output logic            scan_test_tie,
  output logic            test_mode_tie
);
  // Reserved inputs stay low for the whole run.
  assign scan_test_tie = 1'b0;
  assign test_mode_tie = 1'b0;

  // The bus starts deselected with every strobe inactive.
  initial begin
    unit_select_n          = 1'b1;
    store_strobe_n         = 1'b1;
    fetch_strobe_n         = 1'b1;
    address_valid_strobe_n = 1'b1;
    data_in                = 8'h5a;
  end

  // Returns the pins to idle; the released data bus shows the inverse of its last value.
  task automatic idle(input logic [1:0] md);
    unit_select_n          <= 1'b1;
    store_strobe_n         <= 1'b1;
    fetch_strobe_n         <= (md == LCDP_BT_ENABLE) ? 1'b0 : 1'b1;
    address_valid_strobe_n <= 1'b1;
    data_in                <= ~data_in;
  endtask

  // One transfer in the style of the strap code md, with status handed back to the bench.
  task automatic xfer(input logic [1:0] md, input logic wr, input logic sel_n, input logic [7:0] wd,
                      output logic [7:0] rd, output logic lvl, output logic saw, output logic ok,
                      output logic rel);
    int n;
    ok  = 1'b0;
    saw = 1'b0;
    rel = 1'b0;
    lvl = 1'b0;
    rd  = 8'hxx;
    @(posedge clk);
    unit_select_n          <= sel_n;
    store_strobe_n         <= !wr;
    fetch_strobe_n         <= (md == LCDP_BT_ENABLE) ? 1'b1 : (md == LCDP_BT_ADDR) ? 1'b0 : wr;
    address_valid_strobe_n <= (md != LCDP_BT_ADDR);
    data_in                <= wr ? wd : ~data_in;
    // Waits for the completion level; the enable style has no handshake, so it holds a fixed time.
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (handshake_oe === 1'b1 && !saw) begin
        saw = 1'b1;
        lvl = handshake_out;
      end
      if ((md == LCDP_BT_ENABLE && n == 12) || (saw && handshake_out !== lvl)) begin
        ok = 1'b1;
        rd = (data_oe === 1'b1) ? data_out : 8'hxx;
        break;
      end
    end
    @(posedge clk);
    idle(md);
    // The pins must be let go shortly after the strobe ends.
    for (n = 0; n < 10; n++) begin
      @(posedge clk);
      #1;
      if (handshake_oe === 1'b0 && data_oe === 1'b0) begin
        rel = 1'b1;
        break;
      end
    end
    repeat (6) @(posedge clk);
  endtask
endmodule  // lcdp_host_model

`default_nettype wire

/* File: tb/test_lcd_ctrl_host_bus_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the host bus port over every strap code.
module test_lcd_ctrl_host_bus_port
  import lcdp_pkg::*;
;
  logic            clk = 1'b0;      // Bench clock, 40 ns period.
  logic            rst_b;           // Raw active-low reset.
  logic      [1:0] bus_type;        // Bus style strap.
  logic            addr_sel;        // Addressing mode strap.
  logic      [7:0] core_rd_data;    // Core read data, set at random by the bench.
  wire logic       unit_select_n, store_strobe_n, fetch_strobe_n, address_valid_strobe_n;
  wire logic [7:0] data_in, data_out, core_wr_data;
  wire logic       data_oe, handshake_out, handshake_oe, scan_test_tie, test_mode_tie;
  wire logic       core_wr_valid, core_rd_req, indirect_mode;
  wire logic [1:0] bus_mode;
  int              err_total = 0, checks = 0, cyc = 0, rd_cnt = 0;
  int              exp_wr[$];       // Writes the model expects at the core side.
  logic      [7:0] got_wr[$];       // Writes seen at the core side.

  lcdp_host_model host (.clk(clk), .handshake_out(handshake_out), .handshake_oe(handshake_oe),
    .data_out(data_out), .data_oe(data_oe), .unit_select_n(unit_select_n), .store_strobe_n(store_strobe_n),
    .fetch_strobe_n(fetch_strobe_n), .address_valid_strobe_n(address_valid_strobe_n), .data_in(data_in),
    .scan_test_tie(scan_test_tie), .test_mode_tie(test_mode_tie));

  lcdp_host_port uut (.clk(clk), .rst_b(rst_b), .unit_select_n(unit_select_n), .store_strobe_n(store_strobe_n),
    .fetch_strobe_n(fetch_strobe_n), .address_valid_strobe_n(address_valid_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .handshake_out(handshake_out), .handshake_oe(handshake_oe),
    .bus_type_select(bus_type), .addressing_mode_select(addr_sel), .scan_test_tie(scan_test_tie),
    .test_mode_tie(test_mode_tie), .core_wr_valid(core_wr_valid), .core_wr_data(core_wr_data),
    .core_rd_req(core_rd_req), .core_rd_data(core_rd_data), .bus_mode(bus_mode), .indirect_mode(indirect_mode));

  // Free-running clock.
  always #20 clk = ~clk;

  // Core-side monitor and hang guard.
  always @(posedge clk) begin
    cyc++;
    if (core_wr_valid === 1'b1) got_wr.push_back(core_wr_data);
    if (core_rd_req === 1'b1) rd_cnt++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // Compares one value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Resets with new straps; reset is only pulsed with the supply steady.
  task automatic do_reset(input logic [1:0] code, input logic ind);
    @(posedge clk);
    rst_b    <= 1'b0;
    bus_type <= code;
    addr_sel <= ind;
    host.idle(code);
    repeat (4) @(posedge clk);
    #1;
    check(handshake_oe, 1'b0);
    check(data_oe, 1'b0);
    check(core_wr_valid, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (14) @(posedge clk);
    #1;
    got_wr.delete();
    check(bus_mode, (code == 2'h3) ? 2'h0 : code);
    check(indirect_mode, ind);
  endtask

  // One transfer against the behavioural model; sel_n high means the port must stay out of it.
  task automatic run(input logic [1:0] md, input logic wr, input logic sel_n);
    logic [7:0] wd, rd;
    logic       lvl, saw, ok, rel;
    int         reads;
    wd    = 8'($urandom);
    reads = rd_cnt;
    @(posedge clk);
    core_rd_data <= 8'($urandom);
    host.xfer(md, wr, sel_n, wd, rd, lvl, saw, ok, rel);
    if (sel_n) begin
      check(saw, 1'b0);
      check(got_wr.size(), 0);
      check(rd_cnt - reads, 0);
    end else begin
      check(ok, 1'b1);
      check(rel, 1'b1);
      check(saw, md != LCDP_BT_ENABLE);
      if (saw) check(lvl, md == LCDP_BT_ADDR);
      if (wr) begin
        exp_wr.push_back(wd);
        check(got_wr.size(), 1);
        if (got_wr.size() > 0) check(got_wr.pop_front(), exp_wr[0]);
        exp_wr.delete();
        got_wr.delete();
      end else begin
        check(rd, core_rd_data);
        check(rd_cnt - reads, 1);
      end
    end
  endtask

  // Main sequence: every strap code with back-to-back reads and writes, then the awkward cases.
  initial begin
    int code;
    int k;
    rst_b        = 1'b0;
    bus_type     = 2'h0;
    addr_sel     = 1'b0;
    core_rd_data = 8'h00;
    void'($urandom(32'haf0b));
    for (code = 0; code < 4; code++) begin
      do_reset(2'(code), 1'(code));
      for (k = 0; k < 4; k++) run(2'(code), 1'(k), 1'b0);
    end
    // A strap change after the straps are taken must not alter the style.
    do_reset(LCDP_BT_GENERIC, 1'b1);
    @(posedge clk);
    bus_type <= LCDP_BT_ADDR;
    run(LCDP_BT_GENERIC, 1'b1, 1'b1);
    run(LCDP_BT_GENERIC, 1'b0, 1'b0);
    run(LCDP_BT_GENERIC, 1'b1, 1'b0);
    check(bus_mode, LCDP_BT_GENERIC);
    // Reset in mid-transfer must quiet the pins at once.
    @(posedge clk);
    host.unit_select_n  <= 1'b0;
    host.fetch_strobe_n <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
    check(handshake_oe, 1'b1);
    check(data_oe, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    check(handshake_oe, 1'b0);
    check(data_oe, 1'b0);
    do_reset(LCDP_BT_ADDR, 1'b0);
    run(LCDP_BT_ADDR, 1'b1, 1'b0);
    results();
  end
endmodule  // test_lcd_ctrl_host_bus_port

`default_nettype wire
